// ---- bench/fba_seq_model.sv ----
// sequencer model: issues commands, loops on a command while busy
// assumes the access unit takes a command at an edge with ready_r high
`timescale 1ns/1ps
module fba_seq_model
(
  input wire logic clock,
  input wire logic ready_r,
  output fba_pkg::fba_cmd_t cmd,
  output logic [fba_pkg::DATA_W-1:0] din
);
  import fba_pkg::*;
  int lat;
  initial
  begin
    cmd = '0;
    din = 16'h0000;
    lat = 0;
  end
  // mode 0 waits for completion, 1 returns once taken, 2 one edge only
  task automatic issue(input fba_cmd_t c, input logic [DATA_W-1:0] d,
                       input int mode);
    int n;
    bit low;
    n = 0;
    low = 0;
    @(posedge clock);
    cmd <= c;
    din <= d;
    do
      @(posedge clock);
    while (mode != 2 && ready_r !== 1'b1);
    cmd <= '0;
    // released bus does not keep its last value
    din <= ~d;
    if (mode == 0 && (c.start_read || c.load_wdata))
    begin
      do
      begin
        @(posedge clock);
        n++;
        if (ready_r === 1'b0)
          low = 1;
      end
      while (!(low && ready_r === 1'b1) && n < 300);
      lat = n;
    end
  endtask
endmodule

// ---- bench/fba_unit_tb.sv ----
// self-checking bench for the frame buffer access unit
// assumes fba_pkg and the sequencer model fba_seq_model
`timescale 1ns/1ps
module fba_unit_tb;
  import fba_pkg::*;
  localparam fba_cmd_t C_HI = 5'h10;
  localparam fba_cmd_t C_LO = 5'h08;
  localparam fba_cmd_t C_SR = 5'h04;
  localparam fba_cmd_t C_WR = 5'h02;
  localparam fba_cmd_t C_RD = 5'h01;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  fba_cmd_t cmd;
  logic [DATA_W-1:0] din;
  logic ready_r;
  logic [DATA_W-1:0] dout_r;
  logic rd_ack_r;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #20 clock = ~clock;

  fba_unit DUT
  (
    .clock(clock),
    .rst_n(rst_n),
    .cmd(cmd),
    .din(din),
    .ready_r(ready_r),
    .dout_r(dout_r),
    .rd_ack_r(rd_ack_r)
  );

  fba_seq_model SEQ
  (
    .clock(clock),
    .ready_r(ready_r),
    .cmd(cmd),
    .din(din)
  );

  task automatic report_and_stop;
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] got,
                       input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cl(input int e);
    check("latency", 16'(SEQ.lat), 16'(e));
  endtask

  // read register onto the bus, check data and acknowledge
  task automatic rd(input logic [15:0] exp);
    SEQ.issue(C_RD, 16'h0000, 0);
    #1;
    check("dout_r", dout_r, exp);
    check("rd_ack_r", {15'h0000, rd_ack_r}, 16'h0001);
  endtask

  task automatic setp(input logic [15:0] hi, input logic [15:0] lo,
                      input bit sr);
    SEQ.issue(C_HI, hi, 0);
    SEQ.issue(sr ? (C_LO | C_SR) : C_LO, lo, 0);
  endtask

  task automatic t_reset;
    check("ready_r", {15'h0000, ready_r}, 16'h0001);
    check("dout_r", dout_r, 16'h0000);
    check("rd_ack_r", {15'h0000, rd_ack_r}, 16'h0000);
  endtask

  task automatic t_normal;
    setp(16'h0000, 16'h0100, 0);
    SEQ.issue(C_WR, 16'hA5C3, 0);
    cl(WRITE_LAT + 1);
    SEQ.issue(C_WR, 16'h3C5A, 0);
    setp(16'h0000, 16'h0100, 1);
    cl(READ_LAT + 1);
    rd(16'hA5C3);
    SEQ.issue(C_SR, 16'h0000, 0);
    cl(READ_LAT + 1);
    rd(16'h3C5A);
  endtask

  task automatic t_fill;
    // fill used only for writes
    SEQ.issue(C_HI, 16'h0010, 0);
    SEQ.issue(C_LO, 16'h0205, 0);
    SEQ.issue(C_WR, 16'h1111, 0);
    SEQ.issue(C_WR, 16'h2222, 0);
    setp(16'h0000, 16'h0204, 1);
    for (int i = 0; i < 8; i++)
    begin
      if (i > 0)
        SEQ.issue(C_SR, 16'h0000, 0);
      rd(i < 4 ? 16'h1111 : 16'h2222);
    end
  endtask

  task automatic t_rmw;
    SEQ.issue(C_HI, 16'h0020, 0);
    SEQ.issue(C_LO | C_SR, 16'h0204, 0);
    cl(RMW_READ_LAT + 1);
    rd(16'h1111);
    rd(16'h1111);
    SEQ.issue(C_WR, 16'h7E81, 0);
    cl(RMW_WRITE_LAT + 1);
    rd(16'h1111);
    SEQ.issue(C_SR, 16'h0000, 0);
    cl(RMW_ABORT_LAT + 1);
    rd(16'h1111);
    // leave the mode well inside the refresh interval
    SEQ.issue(C_HI, 16'h0000, 0);
    setp(16'h0000, 16'h0204, 1);
    rd(16'h7E81);
    SEQ.issue(C_SR, 16'h0000, 0);
    rd(16'h1111);
  endtask

  task automatic t_busy;
    setp(16'h0000, 16'h0300, 0);
    SEQ.issue(C_WR, 16'hB001, 1);
    SEQ.issue(C_LO | C_WR | C_RD, 16'h0400, 2);
    #1;
    check("rd_ack_r", {15'h0000, rd_ack_r}, 16'h0000);
    SEQ.issue(C_WR, 16'hB002, 0);
    setp(16'h0000, 16'h0300, 1);
    rd(16'hB001);
    SEQ.issue(C_SR, 16'h0000, 0);
    rd(16'hB002);
  endtask

  task automatic t_wrap;
    setp(16'h000F, 16'hFFFF, 0);
    SEQ.issue(C_WR, 16'hD00D, 0);
    SEQ.issue(C_WR, 16'hE00E, 0);
    setp(16'h000F, 16'hFFFF, 1);
    rd(16'hD00D);
    // start-read from the last word wraps to word zero
    SEQ.issue(C_SR, 16'h0000, 0);
    rd(16'hE00E);
    setp(16'h0000, 16'h0000, 1);
    rd(16'hE00E);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_normal();
    t_fill();
    t_rmw();
    t_busy();
    t_wrap();
    report_and_stop();
  end
endmodule

// ---- verilog/fba_pkg.sv ----
// constants, types and commands of the frame buffer access unit
// assumes one processor clock and commands sampled on its rising edge
// What this block does
// - one million 16-bit words, pointer and data registers
// - normal mode, fill submode, read-modify-write mode
// - start-read with low load reads unincremented, 3 cycles
// - lone start-read increments pointer, reads 3 cycles later
// - write-data load writes, pointer increments after 3 cycles
// - fill write stores four aligned locations
// - fill write sets pointer to its aligned base plus four
// - RMW read data after four cycles, stays waiting
// - RMW write completes, increments, next data in five
// - start-read aborts RMW, increments, next data in four
// - busy on operation start, ready on completion
// - protected operations while busy are ignored
// - ready flag offered as branch condition
// - hidden refresh, shown as busy
package fba_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LO_W = 16;
  localparam int HI_ADDR_W = ADDR_W - LO_W;
  localparam int HI_FILL_BIT = 4;
  localparam int HI_RMW_BIT = 5;
  localparam int FILL_WORDS = 4;
  localparam logic [ADDR_W-1:0] PTR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int READ_LAT = 3;
  localparam int WRITE_LAT = 3;
  localparam int RMW_READ_LAT = 4;
  localparam int RMW_WRITE_LAT = 5;
  localparam int RMW_ABORT_LAT = 4;
  localparam int REFRESH_CYC = 2;
  localparam int REFRESH_INTERVAL_NS = 10000;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int REF_CNT_W = $clog2(REFRESH_INTERVAL_CYC);
  localparam int CNT_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_RMW_READ = 3'b011,
    ST_RMW_WAIT = 3'b100,
    ST_REFRESH = 3'b101
  } fba_state_t;

  typedef struct packed {
    logic load_hi;
    logic load_lo;
    logic start_read;
    logic load_wdata;
    logic read_rdata;
  } fba_cmd_t;
endpackage

// ---- verilog/fba_unit.sv ----
// frame buffer access unit: pointer, data registers, DRAM sequencing
// assumes commands and operand data synchronous to the processor clock
`timescale 1ns/1ps
module fba_unit
(
  input wire logic clock,
  input wire logic rst_n,
  input wire fba_pkg::fba_cmd_t cmd,
  input wire logic [fba_pkg::DATA_W-1:0] din,
  output logic ready_r,
  output logic [fba_pkg::DATA_W-1:0] dout_r,
  output logic rd_ack_r
);
  import fba_pkg::*;

  // frame store array, no reset
  logic [DATA_W-1:0] mem [2**ADDR_W];
  fba_state_t state_r;
  fba_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [ADDR_W-1:0] ptr_r;
  logic [ADDR_W-1:0] ptr_nxt;
  logic [ADDR_W-1:0] fill_base;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic fill_r;
  logic rmw_r;
  logic [REF_CNT_W-1:0] ref_cnt_r;
  logic ref_due_r;
  logic acc_sr;
  logic acc_lo;
  logic acc_hi;
  logic acc_rd;
  logic wr_go;
  logic in_wait;
  logic done;
  logic ref_tick;

  // protected operations only take effect while ready
  assign acc_sr = ready_r & cmd.start_read;
  assign acc_lo = ready_r & cmd.load_lo;
  assign acc_hi = ready_r & cmd.load_hi;
  assign acc_rd = ready_r & cmd.read_rdata;
  // start-read wins over a coincident write-data load
  assign wr_go = ready_r & cmd.load_wdata & ~cmd.start_read;
  assign in_wait = (state_r == ST_RMW_WAIT);
  assign done = (cnt_r == '0);
  assign fill_base = {ptr_r[ADDR_W-1:2], 2'b00};
  assign ref_tick =
    (ref_cnt_r == REF_CNT_W'(REFRESH_INTERVAL_CYC - 1));

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE:
      begin
        if (acc_sr)
        begin
          state_nxt = rmw_r ? ST_RMW_READ : ST_READ;
          cnt_nxt = rmw_r ? CNT_W'(RMW_READ_LAT - 1)
                          : CNT_W'(READ_LAT - 1);
        end
        else if (wr_go)
        begin
          state_nxt = ST_WRITE;
          cnt_nxt = CNT_W'(WRITE_LAT - 1);
        end
        else if (ref_due_r)
        begin
          state_nxt = ST_REFRESH;
          cnt_nxt = CNT_W'(REFRESH_CYC - 1);
        end
      end
      ST_READ, ST_WRITE, ST_REFRESH:
      begin
        if (done)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      ST_RMW_READ:
      begin
        if (done)
          state_nxt = ST_RMW_WAIT;
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      ST_RMW_WAIT:
      begin
        if (acc_sr)
        begin
          state_nxt = ST_RMW_READ;
          cnt_nxt = CNT_W'(RMW_ABORT_LAT - 1);
        end
        else if (wr_go)
        begin
          state_nxt = ST_RMW_READ;
          cnt_nxt = CNT_W'(RMW_WRITE_LAT - 1);
        end
        else if (acc_hi && !din[HI_RMW_BIT])
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // busy on an accepted read or write, ready when data or write done
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ready_r <= 1'b1;
    else
      ready_r <= (state_nxt == ST_IDLE) ||
                 (state_nxt == ST_RMW_WAIT);
  end

  always_comb
  begin
    ptr_nxt = ptr_r;
    if (acc_sr && !cmd.load_lo)
      ptr_nxt = ptr_r + 1'b1;
    if (in_wait && wr_go)
      ptr_nxt = ptr_r + 1'b1;
    if (state_r == ST_WRITE && done)
    begin
      if (fill_r)
        ptr_nxt = fill_base + ADDR_W'(FILL_WORDS);
      else
        ptr_nxt = ptr_r + 1'b1;
    end
    if (acc_hi)
      ptr_nxt[ADDR_W-1:LO_W] = din[HI_ADDR_W-1:0];
    if (acc_lo)
      ptr_nxt[LO_W-1:0] = din[LO_W-1:0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= PTR_RST;
    else
      ptr_r <= ptr_nxt;
  end

  // mode bits ride in the high pointer half
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fill_r <= 1'b0;
      rmw_r <= 1'b0;
    end
    else if (acc_hi)
    begin
      fill_r <= din[HI_FILL_BIT];
      rmw_r <= din[HI_RMW_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wdata_r <= DATA_RST;
    else if (wr_go)
      wdata_r <= din;
  end

  always_ff @(posedge clock)
  begin
    if (in_wait && wr_go)
      mem[ptr_r] <= din;
    else if (state_r == ST_WRITE && done)
    begin
      if (fill_r)
      begin
        for (int i = 0; i < FILL_WORDS; i++)
          mem[fill_base + ADDR_W'(i)] <= wdata_r;
      end
      else
        mem[ptr_r] <= wdata_r;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= DATA_RST;
    else if (done &&
             (state_r == ST_READ || state_r == ST_RMW_READ))
      rdata_r <= mem[ptr_r];
  end

  // reading the read-data register never ends an RMW cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_r <= DATA_RST;
      rd_ack_r <= 1'b0;
    end
    else
    begin
      rd_ack_r <= acc_rd;
      if (acc_rd)
        dout_r <= rdata_r;
    end
  end

  // refresh request; a new request wins over its own clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_cnt_r <= '0;
      ref_due_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= ref_tick ? '0 : ref_cnt_r + 1'b1;
      if (ref_tick)
        ref_due_r <= 1'b1;
      else if (state_nxt == ST_REFRESH)
        ref_due_r <= 1'b0;
    end
  end

  property p_norm_read;
    @(posedge clock) disable iff (!rst_n)
    (acc_sr && state_r == ST_IDLE && !rmw_r)
      |=> !ready_r [*3] ##1 ready_r;
  endproperty
  a_norm_read: assert property (p_norm_read)
    else $error("normal read latency wrong");

  property p_lone_inc;
    @(posedge clock) disable iff (!rst_n)
    (acc_sr && !cmd.load_lo && !cmd.load_hi)
      |=> ptr_r == ADDR_W'($past(ptr_r) + 1'b1);
  endproperty
  a_lone_inc: assert property (p_lone_inc)
    else $error("start-read did not increment pointer");

  property p_lo_load;
    @(posedge clock) disable iff (!rst_n)
    acc_lo |=> ptr_r[LO_W-1:0] == $past(din);
  endproperty
  a_lo_load: assert property (p_lo_load)
    else $error("low pointer load lost");

  property p_norm_write;
    @(posedge clock) disable iff (!rst_n)
    (wr_go && state_r == ST_IDLE && !fill_r)
      |=> !ready_r [*3] ##1
          (ready_r && ptr_r == ADDR_W'($past(ptr_r, 4) + 1'b1));
  endproperty
  a_norm_write: assert property (p_norm_write)
    else $error("normal write timing or increment wrong");

  property p_fill_write;
    @(posedge clock) disable iff (!rst_n)
    (wr_go && state_r == ST_IDLE && fill_r)
      |=> !ready_r [*3] ##1
          (ptr_r == ADDR_W'($past(fill_base, 4) + 3'd4));
  endproperty
  a_fill_write: assert property (p_fill_write)
    else $error("fill write did not advance by four");

  property p_rmw_read;
    @(posedge clock) disable iff (!rst_n)
    (acc_sr && state_r == ST_IDLE && rmw_r)
      |=> !ready_r [*4] ##1 (ready_r && in_wait);
  endproperty
  a_rmw_read: assert property (p_rmw_read)
    else $error("rmw read latency wrong");

  property p_rmw_write;
    @(posedge clock) disable iff (!rst_n)
    (in_wait && wr_go) |=> !ready_r [*5] ##1 ready_r;
  endproperty
  a_rmw_write: assert property (p_rmw_write)
    else $error("rmw write latency wrong");

  property p_rmw_abort;
    @(posedge clock) disable iff (!rst_n)
    (in_wait && acc_sr)
      |=> !ready_r [*4] ##1 (ready_r && in_wait);
  endproperty
  a_rmw_abort: assert property (p_rmw_abort)
    else $error("rmw abort latency wrong");

  property p_busy_protect;
    @(posedge clock) disable iff (!rst_n)
    (!ready_r && cmd.load_wdata) |=> $stable(wdata_r);
  endproperty
  a_busy_protect: assert property (p_busy_protect)
    else $error("write-data changed while busy");

  property p_refresh_busy;
    @(posedge clock) disable iff (!rst_n)
    (state_r == ST_REFRESH) |-> !ready_r;
  endproperty
  a_refresh_busy: assert property (p_refresh_busy)
    else $error("ready shown during refresh");

  property p_wrap;
    @(posedge clock) disable iff (!rst_n)
    (acc_sr && !cmd.load_lo && !cmd.load_hi && (&ptr_r))
      |=> ptr_r == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap");
endmodule
